// *** core/rtsse_pkg.sv ***
// Operation
// [RULE1] Conditional return pops only when flag matches
// [RULE2] g: keep, restore, set or clear enable
// [RULE3] rf one restores flags and bank selection
// [RULE4] Omitted g and rf encode as zero
// [RULE5] Unconditional return always pops into counter
// [RULE6] Selector picks Z,C,V,N then link bits
// [RULE7] Conditions test each flag set or clear
// [RULE8] Conditional return: two or three cycles
// [RULE9] Rotate right zero to seven, carry copy
// [RULE10] Left shift, zeros in, last out carry
// [RULE11] Right shift, zeros in, last out carry
// [RULE12] Source minus accumulator minus carry, NZCV
// [RULE13] Register minus immediate written back, NZCV
// [RULE14] Source minus accumulator to register/memory
// [RULE15] Immediate forms accept registers zero to fifteen
// [RULE16] Active accumulator follows bank selection
// [RULE17] Trap pushes counter, enable, flags, banks
// [RULE18] Trap target is base then vector
// [RULE19] Trap clears enable only when operand one
// [RULE20] Hardware interrupt vectors fixed, trap reusable
// [RULE21] XOR immediate writes back, updates N, Z
package rtsse_pkg;

  typedef enum logic [3:0] {
    OP_COND_POP  = 4'h0,
    OP_POP       = 4'h1,
    OP_TRAP      = 4'h2,
    OP_CIRC      = 4'h3,
    OP_LSHIFT    = 4'h4,
    OP_RSHIFT    = 4'h5,
    OP_SBC_ACC   = 4'h6,
    OP_SUB_IMM   = 4'h7,
    OP_SUB_ACC   = 4'h8,
    OP_XOR_IMM   = 4'h9
  } rtsse_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_T2   = 3'b010,
    ST_T3   = 3'b100
  } rtsse_state_t;

  // Flag field positions double as the low half of the condition selector.
  localparam int unsigned FLAG_Z = 0;
  localparam int unsigned FLAG_C = 1;
  localparam int unsigned FLAG_V = 2;
  localparam int unsigned FLAG_N = 3;

  localparam logic [1:0] G_KEEP    = 2'h0; // [RULE4]
  localparam logic [1:0] G_RESTORE = 2'h1;
  localparam logic [1:0] G_SET     = 2'h2;
  localparam logic [1:0] G_CLEAR   = 2'h3;

  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [3:0]  FLAGS_RESET = 4'h0;
  localparam logic        IRQ_EN_RESET = 1'b0;
  localparam logic [1:0]  BANK_RESET  = 2'h0;
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam int unsigned LIMITED_REGS = 16;

  localparam int unsigned TSTATES_FAIL  = 2; // [RULE8]
  localparam int unsigned TSTATES_TAKEN = 3; // [RULE8]

  // Hardware vectors that a trap may reuse.
  localparam logic [5:0] VEC_NONMASK_IRQ     = 6'h1c; // [RULE20]
  localparam logic [5:0] VEC_RX_SERVICE_IRQ  = 6'h04; // [RULE20]
  localparam logic [5:0] VEC_TX_QUEUE_EMPTY  = 6'h08; // [RULE20]
  localparam logic [5:0] VEC_LINE_TURNAROUND = 6'h0c; // [RULE20]
  localparam logic [5:0] VEC_HOST_IRQ        = 6'h10; // [RULE20]
  localparam logic [5:0] VEC_TIMER_EXPIRY    = 6'h14; // [RULE20]

  typedef struct packed {
    rtsse_op_t  op;
    logic [2:0] flag_sel;
    logic       flag_state;
    logic [1:0] g;
    logic       rf;
    logic       g_trap;
    logic [2:0] shift;
    logic [7:0] imm;
    logic [5:0] vector;
    logic [4:0] src_idx;
    logic [4:0] dst_idx;
    logic       dst_mem;
  } rtsse_instr_t;

  typedef struct packed {
    logic [15:0] pc;
    logic        irq_en;
    logic [3:0]  flags;
    logic [1:0]  bank;
  } rtsse_stack_t;

endpackage

// *** core/rtsse_alu_if.sv ***
`timescale 1ns/1ps
interface rtsse_alu_if;
  rtsse_pkg::rtsse_op_t op;
  logic [7:0]           a;
  logic [7:0]           b;
  logic [2:0]           count;
  logic [3:0]           flags_in;
  logic [7:0]           result;
  logic [3:0]           flags_out;

  modport exec (output op, a, b, count, flags_in, input result, flags_out);
  modport alu  (input op, a, b, count, flags_in, output result, flags_out);
endinterface

// *** core/rtsse_alu.sv ***
`timescale 1ns/1ps
module rtsse_alu (
  rtsse_alu_if.alu bus
);

  logic [15:0] wide;
  logic [8:0]  diff;
  logic        borrow;
  logic [3:0]  fl;
  logic [7:0]  res;

  always_comb begin
    wide   = 16'h0000;
    diff   = 9'h000;
    borrow = 1'b0;
    fl     = bus.flags_in;
    res    = bus.a;
    case (bus.op)
      rtsse_pkg::OP_CIRC: begin
        wide = {bus.a, bus.a} >> bus.count;
        res  = wide[7:0];
        if (bus.count != 3'h0) begin
          fl[rtsse_pkg::FLAG_C] = res[7]; // [RULE9]
        end
      end
      rtsse_pkg::OP_LSHIFT: begin
        wide = {8'h00, bus.a} << bus.count;
        res  = wide[7:0];
        if (bus.count != 3'h0) begin
          fl[rtsse_pkg::FLAG_C] = wide[8]; // [RULE10]
        end
      end
      rtsse_pkg::OP_RSHIFT: begin
        wide = {bus.a, 8'h00} >> bus.count;
        res  = wide[15:8];
        if (bus.count != 3'h0) begin
          fl[rtsse_pkg::FLAG_C] = wide[7]; // [RULE11]
        end
      end
      rtsse_pkg::OP_SBC_ACC, rtsse_pkg::OP_SUB_IMM, rtsse_pkg::OP_SUB_ACC: begin
        // Carry acts as a borrow: set when the difference wrapped below zero.
        borrow = (bus.op == rtsse_pkg::OP_SBC_ACC) & bus.flags_in[rtsse_pkg::FLAG_C]; // [RULE12]
        diff   = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, borrow}; // [RULE13] [RULE14]
        res    = diff[7:0];
        fl[rtsse_pkg::FLAG_C] = diff[8];
        fl[rtsse_pkg::FLAG_V] = (bus.a[7] ^ bus.b[7]) & (res[7] ^ bus.a[7]);
      end
      rtsse_pkg::OP_XOR_IMM: begin
        res = bus.a ^ bus.b; // [RULE21]
      end
      default: begin
        res = bus.a;
      end
    endcase
    fl[rtsse_pkg::FLAG_N] = res[7];
    fl[rtsse_pkg::FLAG_Z] = (res == 8'h00);
  end

  assign bus.result    = res;
  assign bus.flags_out = fl;

endmodule

// *** core/rtsse_exec.sv ***
`timescale 1ns/1ps
module rtsse_exec #(
  parameter int unsigned STACK_DEPTH = 16
) (
  // Clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  // Instruction issue
  input  wire logic                 op_valid_i,
  input  wire rtsse_pkg::rtsse_op_t op_code_i,
  input  wire logic [2:0]           flag_sel_i,
  input  wire logic                 flag_state_i,
  input  wire logic [1:0]           g_i,
  input  wire logic                 rf_i,
  input  wire logic                 g_trap_i,
  input  wire logic [2:0]           shift_i,
  input  wire logic [7:0]           imm_i,
  input  wire logic [5:0]           vector_i,
  input  wire logic [4:0]           src_idx_i,
  input  wire logic [4:0]           dst_idx_i,
  input  wire logic                 dst_mem_i,
  output logic                      op_ready_o,
  output logic                      op_done_o,
  output logic                      op_illegal_o,
  // Environment
  input  wire logic [7:0]           irq_vector_base_i,
  // Link status pins
  input  wire logic                 rx_active_i,
  input  wire logic                 rx_fault_i,
  input  wire logic                 rx_byte_ready_i,
  input  wire logic                 tx_queue_full_i,
  // Data memory write
  output logic                      dmem_we_o,
  output logic [7:0]                dmem_wdata_o,
  // Register inspection
  input  wire logic [4:0]           reg_rd_idx_i,
  output logic [7:0]                reg_rd_data_o,
  // Processor state
  output logic [15:0]               pc_o,
  output logic                      global_irq_enable_o,
  output logic [3:0]                alu_flags_o,
  output logic [1:0]                bank_o,
  output logic [$clog2(STACK_DEPTH)-1:0] stack_level_o
);

  localparam int unsigned SPW = $clog2(STACK_DEPTH);

  rtsse_pkg::rtsse_state_t state;
  rtsse_pkg::rtsse_state_t next_state;
  rtsse_pkg::rtsse_instr_t ins;
  rtsse_pkg::rtsse_stack_t stack_mem [STACK_DEPTH];
  rtsse_pkg::rtsse_stack_t popped;
  rtsse_pkg::rtsse_stack_t pushed;

  logic [7:0]     regs [32];
  logic [7:0]     alt_acc;
  logic [15:0]    pc;
  logic           irq_en;
  logic [3:0]     flags;
  logic [1:0]     bank;
  logic [SPW-1:0] sp;

  logic [3:0] link_meta;
  logic [3:0] link_sync;

  logic       exec;
  logic       is_alu;
  logic       acc_form;
  logic       imm_form;
  logic       illegal;
  logic       wr_en;
  logic       cond_true;
  logic       do_pop;
  logic       do_push;
  logic       finish;
  logic [7:0] cond_vec;
  logic [7:0] acc_val;

  rtsse_alu_if alu_bus ();

  rtsse_alu u_alu (
    .bus (alu_bus.alu)
  );

  // Link status pins come from the transceiver's own clock.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_meta <= 4'h0;
      link_sync <= 4'h0;
    end else begin
      link_meta <= {tx_queue_full_i, rx_byte_ready_i, rx_fault_i, rx_active_i};
      link_sync <= link_meta;
    end
  end

  function automatic logic [7:0] read_reg(input logic [4:0] idx);
    if (idx == 5'h00) begin
      read_reg = bank[0] ? alt_acc : regs[0]; // [RULE16]
    end else begin
      read_reg = regs[idx];
    end
  endfunction

  always_comb begin
    exec     = (state == rtsse_pkg::ST_T2);
    acc_form = (ins.op == rtsse_pkg::OP_SBC_ACC) || (ins.op == rtsse_pkg::OP_SUB_ACC);
    imm_form = (ins.op == rtsse_pkg::OP_SUB_IMM) || (ins.op == rtsse_pkg::OP_XOR_IMM);
    is_alu   = acc_form || imm_form || (ins.op == rtsse_pkg::OP_CIRC)
               || (ins.op == rtsse_pkg::OP_LSHIFT) || (ins.op == rtsse_pkg::OP_RSHIFT);
    illegal  = exec && imm_form
               && (ins.dst_idx >= 5'(rtsse_pkg::LIMITED_REGS)); // [RULE15]
    wr_en    = exec && is_alu && !illegal;
    acc_val  = bank[0] ? alt_acc : regs[0]; // [RULE16]
  end

  // Selector order is Z, C, V, N, then the four link bits.
  always_comb begin
    cond_vec = {link_sync[3], link_sync[2], link_sync[1], link_sync[0],
                flags[rtsse_pkg::FLAG_N], flags[rtsse_pkg::FLAG_V],
                flags[rtsse_pkg::FLAG_C], flags[rtsse_pkg::FLAG_Z]}; // [RULE6]
    cond_true = (cond_vec[ins.flag_sel] == ins.flag_state); // [RULE1] [RULE7]
  end

  always_comb begin
    alu_bus.exec.op       = ins.op;
    alu_bus.exec.a        = acc_form ? read_reg(ins.src_idx) : read_reg(ins.dst_idx);
    alu_bus.exec.b        = acc_form ? acc_val : ins.imm;
    alu_bus.exec.count    = ins.shift;
    alu_bus.exec.flags_in = flags;
  end

  always_comb begin
    do_pop  = ((state == rtsse_pkg::ST_T2) && (ins.op == rtsse_pkg::OP_POP))
              || (state == rtsse_pkg::ST_T3); // [RULE5]
    do_push = exec && (ins.op == rtsse_pkg::OP_TRAP);
    popped  = stack_mem[sp - SPW'(1)];
    pushed  = '{pc: pc + 16'h0001, irq_en: irq_en, flags: flags, bank: bank}; // [RULE17]
  end

  always_comb begin
    next_state = state;
    finish     = 1'b0;
    case (state)
      rtsse_pkg::ST_IDLE: begin
        if (op_valid_i) begin
          next_state = rtsse_pkg::ST_T2;
        end
      end
      rtsse_pkg::ST_T2: begin
        if ((ins.op == rtsse_pkg::OP_COND_POP) && cond_true) begin
          next_state = rtsse_pkg::ST_T3; // [RULE8]
        end else begin
          next_state = rtsse_pkg::ST_IDLE;
          finish     = 1'b1;
        end
      end
      rtsse_pkg::ST_T3: begin
        next_state = rtsse_pkg::ST_IDLE;
        finish     = 1'b1;
      end
      default: begin
        next_state = rtsse_pkg::ST_IDLE;
      end
    endcase
  end

  assign op_ready_o = (state == rtsse_pkg::ST_IDLE);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= rtsse_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Fields are held for the whole instruction so the issuer may move on.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ins <= '0;
    end else if (op_valid_i && op_ready_o) begin
      ins.op         <= op_code_i;
      ins.flag_sel   <= flag_sel_i;
      ins.flag_state <= flag_state_i;
      ins.g          <= g_i;
      ins.rf         <= rf_i;
      ins.g_trap     <= g_trap_i;
      ins.shift      <= shift_i;
      ins.imm        <= imm_i;
      ins.vector     <= vector_i;
      ins.src_idx    <= src_idx_i;
      ins.dst_idx    <= dst_idx_i;
      ins.dst_mem    <= dst_mem_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_done_o    <= 1'b0;
      op_illegal_o <= 1'b0;
    end else begin
      op_done_o    <= finish;
      op_illegal_o <= illegal; // [RULE15]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc <= rtsse_pkg::PC_RESET;
    end else if (do_pop) begin
      pc <= popped.pc; // [RULE1] [RULE5]
    end else if (do_push) begin
      pc <= {irq_vector_base_i, 2'b00, ins.vector}; // [RULE18]
    end else if (finish) begin
      pc <= pc + 16'h0001;
    end
  end

  // Global interrupt enable: g applies in the same cycle as the pop on both return forms.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_en <= rtsse_pkg::IRQ_EN_RESET;
    end else if (do_pop) begin
      case (ins.g)
        rtsse_pkg::G_KEEP:    irq_en <= irq_en; // [RULE2] [RULE4]
        rtsse_pkg::G_RESTORE: irq_en <= popped.irq_en; // [RULE2]
        rtsse_pkg::G_SET:     irq_en <= 1'b1; // [RULE2]
        rtsse_pkg::G_CLEAR:   irq_en <= 1'b0; // [RULE2]
        default:              irq_en <= irq_en;
      endcase
    end else if (do_push && ins.g_trap) begin
      irq_en <= 1'b0; // [RULE19]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags <= rtsse_pkg::FLAGS_RESET;
    end else if (do_pop && ins.rf) begin
      flags <= popped.flags; // [RULE3]
    end else if (wr_en) begin
      flags <= alu_bus.exec.flags_out;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank <= rtsse_pkg::BANK_RESET;
    end else if (do_pop && ins.rf) begin
      bank <= popped.bank; // [RULE3]
    end
  end

  // The stack wraps silently; deeper nesting overwrites the oldest entry.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_mem[i] <= '0;
      end
    end else if (do_push) begin
      stack_mem[sp] <= pushed; // [RULE17]
      sp            <= sp + SPW'(1);
    end else if (do_pop) begin
      sp <= sp - SPW'(1); // [RULE5]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alt_acc <= rtsse_pkg::REG_RESET;
      for (int i = 0; i < 32; i++) begin
        regs[i] <= rtsse_pkg::REG_RESET;
      end
    end else if (wr_en && !(acc_form && ins.dst_mem)) begin
      if ((ins.dst_idx == 5'h00) && bank[0]) begin
        alt_acc <= alu_bus.exec.result; // [RULE16]
      end else begin
        regs[ins.dst_idx] <= alu_bus.exec.result; // [RULE9] [RULE13] [RULE21]
      end
    end
  end

  // Only the accumulator subtracts may target data memory.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dmem_we_o    <= 1'b0;
      dmem_wdata_o <= 8'h00;
    end else begin
      dmem_we_o <= wr_en && acc_form && ins.dst_mem; // [RULE12] [RULE14]
      if (wr_en && acc_form && ins.dst_mem) begin
        dmem_wdata_o <= alu_bus.exec.result;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rd_data_o <= 8'h00;
    end else begin
      reg_rd_data_o <= read_reg(reg_rd_idx_i);
    end
  end

  always_comb begin
    pc_o                = pc;
    global_irq_enable_o = irq_en;
    alu_flags_o         = flags;
    bank_o              = bank;
    stack_level_o       = sp;
  end

endmodule

// *** tb/rtsse_exec_props.sv ***
`timescale 1ns/1ps
module rtsse_exec_props #(
  parameter int unsigned STACK_DEPTH = 16
) (
  // Clock, reset and issue
  input wire logic                         core_clk_i,
  input wire logic                         rst_n_i,
  input wire logic                         op_valid_i,
  input wire rtsse_pkg::rtsse_op_t         op_code_i,
  input wire logic [2:0]                   flag_sel_i,
  input wire logic                         flag_state_i,
  input wire logic [1:0]                   g_i,
  input wire logic                         rf_i,
  input wire logic                         g_trap_i,
  input wire logic [5:0]                   vector_i,
  input wire logic [4:0]                   dst_idx_i,
  input wire logic [7:0]                   irq_vector_base_i,
  // Outputs watched
  input wire logic                         op_ready_o,
  input wire logic                         op_done_o,
  input wire logic                         op_illegal_o,
  input wire logic [15:0]                  pc_o,
  input wire logic                         global_irq_enable_o,
  input wire logic [3:0]                   alu_flags_o,
  input wire logic [1:0]                   bank_o,
  input wire logic [$clog2(STACK_DEPTH)-1:0] stack_level_o
);
  wire tk = op_valid_i && op_ready_o;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  busy_after_take_a: assert property (tk |=> !op_ready_o)
    else $error("ready stayed high after an issue");
  two_state_done_a: assert property (
    tk && op_code_i != rtsse_pkg::OP_COND_POP |-> ##2 op_done_o)
    else $error("two cycle operation did not finish in time");
  cond_ret_time_a: assert property (
    tk && op_code_i == rtsse_pkg::OP_COND_POP && !flag_sel_i[2] |->
    ##2 op_done_o == (alu_flags_o[$past(flag_sel_i, 2)] != $past(flag_state_i, 2)))
    else $error("conditional return length does not follow its flag");
  trap_target_a: assert property (
    tk && op_code_i == rtsse_pkg::OP_TRAP |->
    ##2 pc_o == {$past(irq_vector_base_i, 2), 2'h0, $past(vector_i, 2)}
    && stack_level_o == $past(stack_level_o, 2) + 1'b1)
    else $error("trap target or push wrong");
  trap_enable_a: assert property (
    tk && op_code_i == rtsse_pkg::OP_TRAP |->
    ##2 global_irq_enable_o == ($past(global_irq_enable_o, 2) && !$past(g_trap_i, 2)))
    else $error("trap enable handling wrong");
  g_force_a: assert property (
    tk && op_code_i == rtsse_pkg::OP_POP && g_i[1] |->
    ##2 global_irq_enable_o == ($past(g_i, 2) == rtsse_pkg::G_SET))
    else $error("return did not set or clear the enable");
  rf_keep_a: assert property (
    tk && op_code_i == rtsse_pkg::OP_POP && !rf_i |->
    ##2 alu_flags_o == $past(alu_flags_o, 2) && bank_o == $past(bank_o, 2))
    else $error("return without restore changed flags or bank");
  illegal_imm_a: assert property (
    tk && (op_code_i == rtsse_pkg::OP_SUB_IMM || op_code_i == rtsse_pkg::OP_XOR_IMM) |->
    ##2 op_illegal_o == ($past(dst_idx_i, 2) >= 5'h10))
    else $error("immediate register range check wrong");
endmodule

bind rtsse_exec rtsse_exec_props #(.STACK_DEPTH(STACK_DEPTH)) props_u (
  .core_clk_i, .rst_n_i, .op_valid_i, .op_code_i, .flag_sel_i, .flag_state_i, .g_i, .rf_i,
  .g_trap_i, .vector_i, .dst_idx_i, .irq_vector_base_i, .op_ready_o, .op_done_o,
  .op_illegal_o, .pc_o, .global_irq_enable_o, .alu_flags_o, .bank_o, .stack_level_o
);

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic                    core_clk_i, rst_n_i, op_valid_i, flag_state_i, rf_i, g_trap_i;
  logic                    dst_mem_i, rx_active_i, rx_fault_i, rx_byte_ready_i, tx_queue_full_i;
  rtsse_pkg::rtsse_op_t    op_code_i, o;
  logic [2:0]              flag_sel_i, shift_i;
  logic [1:0]              g_i, bank_o;
  logic [7:0]              imm_i, irq_vector_base_i, dmem_wdata_o, reg_rd_data_o;
  logic [5:0]              vector_i;
  logic [4:0]              src_idx_i, dst_idx_i, reg_rd_idx_i;
  logic                    op_ready_o, op_done_o, op_illegal_o, dmem_we_o, global_irq_enable_o;
  logic [15:0]             pc_o, epc;
  logic [3:0]              alu_flags_o, stack_level_o, ef, pins;
  logic [11:0]             r;
  logic [7:0]              m [16];
  logic                    egie, il, acc, tk;
  integer                  seed = 60;
  int                      err_total = 0, n_compared = 0, cyc = 0, n;
  rtsse_pkg::rtsse_stack_t stk [$], e;
  logic [5:0]              hw [6] = '{rtsse_pkg::VEC_NONMASK_IRQ, rtsse_pkg::VEC_RX_SERVICE_IRQ,
    rtsse_pkg::VEC_TX_QUEUE_EMPTY, rtsse_pkg::VEC_LINE_TURNAROUND, rtsse_pkg::VEC_HOST_IRQ,
    rtsse_pkg::VEC_TIMER_EXPIRY};

  assign {tx_queue_full_i, rx_byte_ready_i, rx_fault_i, rx_active_i} = pins;

  rtsse_exec dut_u (
    .core_clk_i, .rst_n_i, .op_valid_i, .op_code_i, .flag_sel_i, .flag_state_i, .g_i, .rf_i,
    .g_trap_i, .shift_i, .imm_i, .vector_i, .src_idx_i, .dst_idx_i, .dst_mem_i, .op_ready_o,
    .op_done_o, .op_illegal_o, .irq_vector_base_i, .rx_active_i, .rx_fault_i,
    .rx_byte_ready_i, .tx_queue_full_i, .dmem_we_o, .dmem_wdata_o, .reg_rd_idx_i,
    .reg_rd_data_o, .pc_o, .global_irq_enable_o, .alu_flags_o, .bank_o, .stack_level_o
  );

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Called just after an edge; returns in the cycle that shows the completion pulse.
  task automatic run(input rtsse_pkg::rtsse_op_t op);
    op_code_i = op;
    op_valid_i = 1'b1;
    @(posedge core_clk_i);
    #1 op_valid_i = 1'b0;
    n = 0;
    while (op_done_o !== 1'b1 && n < 8) begin
      @(posedge core_clk_i);
      #1 n++;
    end
  endtask

  function automatic logic [11:0] alu(rtsse_pkg::rtsse_op_t op, logic [7:0] a, logic [7:0] b,
                                      logic [2:0] k, logic [3:0] f);
    logic [8:0] x;
    logic       c;
    logic       v;
    x = {1'b0, a};
    c = f[1];
    v = f[2];
    case (op)
      rtsse_pkg::OP_CIRC: begin
        x[7:0] = 8'({a, a} >> k);
        if (k != 0) c = x[7];
      end
      rtsse_pkg::OP_LSHIFT: begin
        x[7:0] = a << k;
        if (k != 0) c = a[8 - k];
      end
      rtsse_pkg::OP_RSHIFT: begin
        x[7:0] = a >> k;
        if (k != 0) c = a[k - 1];
      end
      rtsse_pkg::OP_XOR_IMM: x[7:0] = a ^ b;
      default: begin
        x = a - b - (op == rtsse_pkg::OP_SBC_ACC && f[1]);
        c = x[8];
        v = (a[7] ^ b[7]) & (a[7] ^ x[7]);
      end
    endcase
    return {x[7], v, c, x[7:0] == 8'h00, x[7:0]};
  endfunction

  initial begin
    rst_n_i = 1'b0;
    op_valid_i = 1'b0;
    op_code_i = rtsse_pkg::OP_CIRC;
    {flag_state_i, rf_i, g_trap_i, dst_mem_i, flag_sel_i, shift_i, g_i, imm_i} = '0;
    {vector_i, src_idx_i, dst_idx_i, reg_rd_idx_i, pins} = '0;
    irq_vector_base_i = 8'($random(seed));
    {epc, egie, ef} = '0;
    foreach (m[i]) m[i] = 8'h00;
    repeat (4) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    for (int i = 0; i < 60; i++) begin
      o = rtsse_pkg::rtsse_op_t'(4'h3 + 4'($unsigned($random(seed)) % 7));
      {dst_mem_i, shift_i, imm_i, src_idx_i, dst_idx_i} = 22'($random(seed));
      // The first seven passes walk every ALU operation at the widest count, with an out-of-range target for the immediate forms.
      if (i < 7) begin
        o = rtsse_pkg::rtsse_op_t'(4'h3 + 4'(i));
        shift_i = 3'h7;
        dst_idx_i[4] = 1'b1;
      end
      src_idx_i[4] = 1'b0;
      acc = o inside {rtsse_pkg::OP_SBC_ACC, rtsse_pkg::OP_SUB_ACC};
      il = dst_idx_i[4] && o inside {rtsse_pkg::OP_SUB_IMM, rtsse_pkg::OP_XOR_IMM};
      if (!il) dst_idx_i[4] = 1'b0;
      if (acc) r = alu(o, m[src_idx_i[3:0]], m[0], shift_i, ef);
      else r = alu(o, m[dst_idx_i[3:0]], imm_i, shift_i, ef);
      run(o);
      chk(op_illegal_o, il);
      chk(dmem_we_o, acc && dst_mem_i);
      if (acc && dst_mem_i) chk(dmem_wdata_o, r[7:0]);
      else if (!il) m[dst_idx_i[3:0]] = r[7:0];
      if (!il) ef = r[11:8];
      epc++;
      chk(alu_flags_o, ef);
      chk(pc_o, epc);
      reg_rd_idx_i = {1'b0, dst_idx_i[3:0]};
      @(posedge core_clk_i);
      #1 chk(reg_rd_data_o, m[dst_idx_i[3:0]]);
    end
    $display("arithmetic and shift test finished");
    repeat (2) begin
      pins = 4'($random(seed));
      for (int i = 0; i < 8; i++) begin
        vector_i = (i < 6) ? hw[i] : 6'($random(seed));
        g_trap_i = 1'($random(seed));
        e = '{epc + 16'h1, egie, ef, 2'h0};
        stk.push_back(e);
        run(rtsse_pkg::OP_TRAP);
        epc = {irq_vector_base_i, 2'h0, vector_i};
        egie = egie && !g_trap_i;
        chk(pc_o, epc);
        chk(global_irq_enable_o, egie);
        chk(stack_level_o, 16'(stk.size()));
      end
      for (int t = 0; t < 40 && stk.size() > 0; t++) begin
        o = $random(seed) & 1 ? rtsse_pkg::OP_POP : rtsse_pkg::OP_COND_POP;
        {rf_i, g_i, flag_sel_i, flag_state_i} = 7'($random(seed));
        tk = (flag_sel_i[2] ? pins[flag_sel_i[1:0]] : ef[flag_sel_i[1:0]]) == flag_state_i;
        tk = tk || o == rtsse_pkg::OP_POP;
        e = stk[$];
        run(o);
        chk(16'(n), (o == rtsse_pkg::OP_COND_POP && tk) ? 16'h2 : 16'h1);
        if (tk) begin
          void'(stk.pop_back());
          epc = e.pc;
          egie = (g_i == 2'h1) ? e.irq_en : (g_i == 2'h0) ? egie : !g_i[0];
          if (rf_i) ef = e.flags;
        end else begin
          epc++;
        end
        chk(pc_o, epc);
        chk(global_irq_enable_o, egie);
        chk(alu_flags_o, ef);
        chk(bank_o, 2'h0);
      end
      $display("trap and return round finished");
    end
    end_of_test();
  end
endmodule
